//--- hw/cps_consts.svh
// Register offsets, field positions, reset values and bus constants
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (SMBus register pointer)
// ----------------------------------------------------------------
`define CPS_REG_ROUTE   3'h0
`define CPS_REG_PE      3'h1
`define CPS_REG_EQ      3'h2
`define CPS_REG_CTRL    3'h3
`define CPS_REG_STATUS  3'h4

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define CPS_CTRL_OUT_EN_LSB  0
`define CPS_CTRL_OUT_EN_MSB  3
`define CPS_CTRL_IGN_EQ      4
`define CPS_CTRL_IGN_PE      5
`define CPS_CTRL_MON_EN      6
`define CPS_CTRL_SOFT_SLEEP  7
`define CPS_CTRL_RESET       8'h0f
`define CPS_ROUTE_RESET      8'h00
`define CPS_PE_RESET         8'h00
`define CPS_EQ_RESET         8'h00
`define CPS_STATUS_RESET     4'h0
`define CPS_RESERVED_READ    4'h0

// ----------------------------------------------------------------
// SMBus slave address (value is arbitrary)
// ----------------------------------------------------------------
`define CPS_SLAVE_ADDR       7'h5c

`endif

//--- hw/cps_pkg.sv
// Types shared by the crosspoint power and signal status logic
package cps_pkg;

  // --------------------------------------------------------------
  // SMBus slave states, one-hot
  // --------------------------------------------------------------
  typedef enum logic [5:0] {
    CPS_IDLE = 6'h01,  // Bus idle or not addressed
    CPS_ADDR = 6'h02,  // Shifting in address byte
    CPS_ACK  = 6'h04,  // Driving acknowledge bit
    CPS_WR   = 6'h08,  // Shifting in pointer or data byte
    CPS_RD   = 6'h10,  // Shifting out data byte
    CPS_RACK = 6'h20   // Sampling host acknowledge
  } cps_smb_state_t;

endpackage

//--- hw/cps_reg_if.sv
// Register access channel between the SMBus slave and the register file
`timescale 1ns/1ps
interface cps_reg_if;
  logic       wr_stb;   // One-cycle write pulse
  logic [2:0] addr;     // Register pointer
  logic [7:0] wr_data;  // Write data
  logic [7:0] rd_data;  // Read data at addr, one cycle late

  modport slave (output wr_stb, output addr, output wr_data,
                 input rd_data);
  modport regs  (input wr_stb, input addr, input wr_data,
                 output rd_data);
endinterface

//--- hw/cps_smb_slave.sv
// SMBus slave: byte shifting, acknowledge and register pointer
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_smb_slave (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // SMBus pins
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Register channel
  cps_reg_if.slave  rb
);

  // --------------------------------------------------------------
  // Pin history and bus events
  // --------------------------------------------------------------
  logic       scl_q;      // Previous scl sample
  logic       sda_q;      // Previous sda sample
  logic       scl_rise;   // Clock rising, sample data
  logic       scl_fall;   // Clock falling, change data
  logic       bus_start;  // Start or repeated start
  logic       bus_stop;   // Stop condition

  // Open drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl & scl_q & ~sda_q & sda_in;

  // Sample history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // --------------------------------------------------------------
  // Transfer state machine
  // --------------------------------------------------------------
  cps_pkg::cps_smb_state_t state;  // Current phase
  logic [2:0] bit_cnt;    // Bits done in the byte
  logic [7:0] shreg;      // Shift register
  logic       byte_done;  // Eight bits taken
  logic       is_read;    // Direction of transfer
  logic       ptr_next;   // Next write byte is the pointer
  logic [2:0] ptr;        // Register pointer

  assign rb.addr = ptr;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= cps_pkg::CPS_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_done <= 1'b0;
      is_read   <= 1'b0;
      ptr_next  <= 1'b0;
      ptr       <= 3'h0;
      sda_oe    <= 1'b0;
      rb.wr_stb <= 1'b0;
      rb.wr_data <= 8'h00;
    end else begin
      rb.wr_stb <= 1'b0;
      if (bus_stop) begin
        // Stop always frees the bus
        state  <= cps_pkg::CPS_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        // Start, including repeated start for reads
        state     <= cps_pkg::CPS_ADDR;
        bit_cnt   <= 3'h0;
        byte_done <= 1'b0;
        sda_oe    <= 1'b0;
      end else begin
        case (state)
          cps_pkg::CPS_ADDR, cps_pkg::CPS_WR: begin
            if (scl_rise) begin
              shreg     <= {shreg[6:0], sda_in};
              bit_cnt   <= bit_cnt + 3'h1;
              byte_done <= (bit_cnt == 3'h7);
            end else if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              if (state == cps_pkg::CPS_ADDR) begin
                // Acknowledge own address only
                if (shreg[7:1] == `CPS_SLAVE_ADDR) begin
                  is_read  <= shreg[0];
                  ptr_next <= ~shreg[0];
                  sda_oe   <= 1'b1;
                  state    <= cps_pkg::CPS_ACK;
                end else begin
                  state <= cps_pkg::CPS_IDLE;
                end
              end else begin
                // First byte is the pointer, later bytes are data
                if (ptr_next) begin
                  ptr      <= shreg[2:0];
                  ptr_next <= 1'b0;
                end else begin
                  rb.wr_stb  <= 1'b1;
                  rb.wr_data <= shreg;
                end
                sda_oe <= 1'b1;
                state  <= cps_pkg::CPS_ACK;
              end
            end
          end
          cps_pkg::CPS_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (is_read) begin
                // Register data was presented during the ack clock
                shreg  <= {rb.rd_data[6:0], 1'b0};
                sda_oe <= ~rb.rd_data[7];
                state  <= cps_pkg::CPS_RD;
              end else begin
                sda_oe <= 1'b0;
                state  <= cps_pkg::CPS_WR;
              end
            end
          end
          cps_pkg::CPS_RD: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                sda_oe <= 1'b0;
                state  <= cps_pkg::CPS_RACK;
              end else begin
                sda_oe <= ~shreg[7];
                shreg  <= {shreg[6:0], 1'b0};
              end
            end
          end
          cps_pkg::CPS_RACK: begin
            // Host nack ends the read; ack asks for the same register
            if (scl_rise) begin
              state <= sda_in ? cps_pkg::CPS_IDLE : cps_pkg::CPS_ACK;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

//--- hw/cps_power_status.sv
// Crosspoint power mode decision, gating and signal status registers
//
// Summary of operation
// - Pin low and soft bit low: power down
// - Monitor enable still wakes inputs when down
// - Pin or soft bit high: power up, gate
// - Output on only if needed and enabled
// - Input on if routed while awake, or monitor enabled
// - Status bits 0-3 per input, reset 0
// - Valid signal on an enabled input reads one in status
// - Status bits 7-4 reserved, read only
// - Control bits 3-0 gate outputs, reset ones
// - Control bit 6 monitor enable, reset zero
// - Control bit 7 soft sleep, ORed pin
// - Status register at 4, writes ignored
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_power_status (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // SMBus pins
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Device pins and analog detectors
  input  wire logic       power_down_pin_n,
  input  wire logic [3:0] lane_detect,
  // Power gating and configuration towards the analog blocks
  output logic            power_up_mode,
  output logic [3:0]      output_enable,
  output logic [3:0]      input_enable,
  output logic [7:0]      route_select,
  output logic [7:0]      pe_level,
  output logic [7:0]      eq_level,
  output logic            ignore_ext_eq,
  output logic            ignore_ext_pe
);

  // --------------------------------------------------------------
  // SMBus slave
  // --------------------------------------------------------------
  cps_reg_if rb ();

  logic sda_out_w;  // Slave data level, always low
  logic sda_oe_w;   // Slave pull-low enable

  cps_smb_slave u_slave (
    .mclk   (mclk),
    .rst    (rst),
    .scl    (scl),
    .sda_in (sda_in),
    .sda_out(sda_out_w),
    .sda_oe (sda_oe_w),
    .rb     (rb.slave)
  );

  // Retime pin drive so the top outputs come from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= sda_out_w;
      sda_oe  <= sda_oe_w;
    end
  end

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  logic [7:0] ctrl;         // Control register
  logic [3:0] lane_status;  // Per input signal valid

  // Software writes; the status offset has no write path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      route_select <= `CPS_ROUTE_RESET;
      pe_level     <= `CPS_PE_RESET;
      eq_level     <= `CPS_EQ_RESET;
      ctrl         <= `CPS_CTRL_RESET;
    end else if (rb.wr_stb) begin
      if (rb.addr == `CPS_REG_ROUTE) begin
        route_select <= rb.wr_data;
      end else if (rb.addr == `CPS_REG_PE) begin
        pe_level <= rb.wr_data;
      end else if (rb.addr == `CPS_REG_EQ) begin
        eq_level <= rb.wr_data;
      end else if (rb.addr == `CPS_REG_CTRL) begin
        ctrl <= rb.wr_data;
      end
      // Status and unmapped offsets drop the write
    end
  end

  // Read mux, one cycle behind the pointer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rb.rd_data <= 8'h00;
    end else if (rb.addr == `CPS_REG_ROUTE) begin
      rb.rd_data <= route_select;
    end else if (rb.addr == `CPS_REG_PE) begin
      rb.rd_data <= pe_level;
    end else if (rb.addr == `CPS_REG_EQ) begin
      rb.rd_data <= eq_level;
    end else if (rb.addr == `CPS_REG_CTRL) begin
      rb.rd_data <= ctrl;
    end else if (rb.addr == `CPS_REG_STATUS) begin
      // Reserved upper nibble reads as a fixed value
      rb.rd_data <= {`CPS_RESERVED_READ, lane_status};
    end else begin
      rb.rd_data <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Power mode decision
  // --------------------------------------------------------------
  logic       awake;       // Pin and soft bit ORed
  logic       mon_en;      // Signal monitor enable
  logic [3:0] routed;      // Input used by some output
  logic [3:0] next_in_en;  // Next input enables

  // True when any output selects input idx
  function automatic logic is_routed(input logic [7:0] sel,
                                     input logic [1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int o = 0; o < 4; o++) begin
      if (sel[2*o +: 2] == idx) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign awake  = power_down_pin_n | ctrl[`CPS_CTRL_SOFT_SLEEP];
  assign mon_en = ctrl[`CPS_CTRL_MON_EN];

  // Each input has its own gating term
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign routed[gi] = is_routed(route_select, 2'(gi));
      // Monitor enable overrides gating in both modes
      assign next_in_en[gi] = (awake & routed[gi]) | mon_en;
    end
  endgenerate

  // Mode and gating flops; every output is always selected by the
  // two-bit route field, so an output is needed whenever awake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_up_mode <= 1'b0;
      output_enable <= 4'h0;
      input_enable  <= 4'h0;
      ignore_ext_eq <= 1'b0;
      ignore_ext_pe <= 1'b0;
    end else begin
      power_up_mode <= awake;
      output_enable <= awake ? ctrl[3:0] : 4'h0;
      input_enable  <= next_in_en;
      ignore_ext_eq <= ctrl[`CPS_CTRL_IGN_EQ];
      ignore_ext_pe <= ctrl[`CPS_CTRL_IGN_PE];
    end
  end

  // --------------------------------------------------------------
  // Signal status tracking
  // --------------------------------------------------------------
  // A gated-off monitor cannot see a signal, so it reports a fault
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lane_status <= `CPS_STATUS_RESET;
    end else begin
      lane_status <= next_in_en & lane_detect;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_sleep_off;
    @(posedge mclk) disable iff (rst)
    (!power_down_pin_n && !ctrl[7]) |=>
      (output_enable == 4'h0) && !power_up_mode;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("outputs on in power-down");

  property p_sleep_monitor;
    @(posedge mclk) disable iff (rst)
    (!awake && mon_en) |=> (input_enable == 4'hf);
  endproperty
  a_sleep_monitor: assert property (p_sleep_monitor)
    else $error("monitor enable ignored in power-down");

  property p_wake_mode;
    @(posedge mclk) disable iff (rst)
    (power_down_pin_n || ctrl[7]) |=> power_up_mode;
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("not in power-up mode");

  property p_out_gate;
    @(posedge mclk) disable iff (rst)
    awake |=> (output_enable == $past(ctrl[3:0]));
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("output enable differs from control bits");

  property p_in_routed;
    @(posedge mclk) disable iff (rst)
    (awake && !mon_en) |=> (input_enable == $past(routed));
  endproperty
  a_in_routed: assert property (p_in_routed)
    else $error("input enable differs from routing");

  property p_status_read;
    @(posedge mclk) disable iff (rst)
    (rb.addr == 3'h4) |=>
      (rb.rd_data == {4'h0, $past(lane_status)});
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read value wrong");

  property p_valid_seen;
    @(posedge mclk) disable iff (rst)
    (mon_en && lane_detect[0]) ##1 (mon_en && lane_detect[0]) |->
      lane_status[0];
  endproperty
  a_valid_seen: assert property (p_valid_seen)
    else $error("valid signal not reported");

  property p_gated_fault;
    @(posedge mclk) disable iff (rst)
    1'b1 |=> ((lane_status & ~input_enable) == 4'h0);
  endproperty
  a_gated_fault: assert property (p_gated_fault)
    else $error("status set on gated input");

  property p_status_ro;
    @(posedge mclk) disable iff (rst)
    (rb.wr_stb && rb.addr == 3'h4) |=>
      $stable(ctrl) && $stable(route_select);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("write to status changed a register");

endmodule

//--- bench/cps_smb_host.sv
// SMBus host model that reads and writes the crosspoint registers
`timescale 1ns/1ps
module cps_smb_host (
  // Clock
  input  wire logic mclk,
  // SMBus wire, pulled up when nobody pulls low
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Bus idles high on both lines
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Lands just after a clock edge so the device never races us
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Bit level: each scl phase lasts four clocks, above the minimum
  // ------------------------------------------------------------
  task automatic bit_cycle(input logic b, output logic s);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    s = sda;
    scl = 1'b0;
    tick(1);
  endtask

  // Start or repeated start: sda falls while scl stays high
  task automatic start();
    sda_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask

  // Stop: sda rises while scl is high
  task automatic stop();
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask

  // Byte out, most significant bit first; returns the acknowledge level
  task automatic send(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, ack_n);
  endtask

  // ------------------------------------------------------------
  // Register transfers
  // ------------------------------------------------------------
  // Pointer then one data byte; ok is high when all bytes were taken
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start();
    send({dev, 1'b0}, a0);
    send(ptr, a1);
    send(data, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask

  // Pointer write, repeated start, one byte back, then a nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic ok);
    logic a0, a1, a2, s;
    start();
    send({dev, 1'b0}, a0);
    send(ptr, a1);
    start();
    send({dev, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(1'b1, s);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule

//--- bench/tb_cps_power_status.sv
// Self-checking bench for power mode, gating and signal status
`timescale 1ns/1ps
module tb_cps_power_status;
  // Device address, arbitrary value shared with the design
  localparam logic [6:0] DEV = 7'h5c;
  logic       mclk, rst, scl, sda, sda_pull, sda_out, sda_oe, pin_n;
  logic       pwr, ign_eq, ign_pe, ok;
  logic [3:0] lanes, oe, ie;
  logic [7:0] route, pe, eq, rd;
  int         errors, checked;

  // One table row: stimulus, then expected gating and status
  typedef struct packed {
    logic       pin;
    logic [7:0] ctrl, rte;
    logic [3:0] lane, eoe, eie, est;
  } cps_row_t;
  cps_row_t rows [0:6] = '{
    '{1'b0, 8'h0f, 8'h00, 4'hf, 4'h0, 4'h0, 4'h0},
    '{1'b0, 8'h4f, 8'h00, 4'hf, 4'h0, 4'hf, 4'hf},
    '{1'b1, 8'h0f, 8'he4, 4'h5, 4'hf, 4'hf, 4'h5},
    '{1'b0, 8'h8a, 8'h00, 4'hf, 4'ha, 4'h1, 4'h1},
    '{1'b1, 8'h05, 8'hff, 4'hf, 4'h5, 4'h8, 4'h8},
    '{1'b1, 8'h40, 8'h55, 4'ha, 4'h0, 4'hf, 4'ha},
    '{1'b1, 8'h3f, 8'h1b, 4'h3, 4'hf, 4'hf, 4'h3}};

  // Open-drain wire with pull-up
  assign sda = ~(sda_pull | sda_oe);

  // Clock, 8 ns period
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  cps_power_status cps_power_status_i (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_down_pin_n(pin_n),
    .lane_detect(lanes), .power_up_mode(pwr), .output_enable(oe),
    .input_enable(ie), .route_select(route), .pe_level(pe),
    .eq_level(eq), .ignore_ext_eq(ign_eq), .ignore_ext_pe(ign_pe));

  cps_smb_host cps_smb_host_i (
    .mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // ------------------------------------------------------------
  // Compare, report and close
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Lets settled outputs be sampled off the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Watchdog, well past the expected run of about 9000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    test_done();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    pin_n = 1'b0;
    lanes = 4'h0;
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    step(2);
    // Reset state: pin low and soft bit clear means asleep
    check({7'h0, pwr}, 8'h00);
    check({oe, ie}, 8'h00);
    cps_smb_host_i.read_reg(DEV, 8'h03, rd, ok);
    check(rd, 8'h0f);
    cps_smb_host_i.read_reg(DEV, 8'h04, rd, ok);
    check({4'h0, rd[3:0]}, 8'h00);
    // Writes to the status register leave it alone
    lanes = 4'hf;
    cps_smb_host_i.write_reg(DEV, 8'h04, 8'hff, ok);
    cps_smb_host_i.read_reg(DEV, 8'h04, rd, ok);
    check({4'h0, rd[3:0]}, 8'h00);
    // The dropped status write must not land in the control register
    cps_smb_host_i.read_reg(DEV, 8'h03, rd, ok);
    check(rd, 8'h0f);
    // Table of pin, control and route combinations
    foreach (rows[k]) begin
      cps_smb_host_i.write_reg(DEV, 8'h00, rows[k].rte, ok);
      cps_smb_host_i.write_reg(DEV, 8'h03, rows[k].ctrl, ok);
      pin_n = rows[k].pin;
      lanes = rows[k].lane;
      step(3);
      check({7'h0, pwr}, {7'h0, rows[k].pin | rows[k].ctrl[7]});
      check({4'h0, oe}, {4'h0, rows[k].eoe});
      check({4'h0, ie}, {4'h0, rows[k].eie});
      check(route, rows[k].rte);
      check({6'h0, ign_pe, ign_eq}, {6'h0, rows[k].ctrl[5:4]});
      cps_smb_host_i.read_reg(DEV, 8'h04, rd, ok);
      check({4'h0, rd[3:0]}, {4'h0, rows[k].est});
      check({7'h0, ok}, 8'h01);
    end
    // Another address is not answered and changes nothing
    cps_smb_host_i.write_reg(7'h2a, 8'h03, 8'h00, ok);
    check({7'h0, ok}, 8'h00);
    cps_smb_host_i.read_reg(DEV, 8'h03, rd, ok);
    check(rd, 8'h3f);
    // Level registers reach their ports
    cps_smb_host_i.write_reg(DEV, 8'h01, 8'h9c, ok);
    cps_smb_host_i.write_reg(DEV, 8'h02, 8'h63, ok);
    step(2);
    check(pe, 8'h9c);
    check(eq, 8'h63);
    // Reset in mid-run returns everything to defaults
    rst = 1'b1;
    step(3);
    check({7'h0, pwr}, 8'h00);
    check({oe, ie}, 8'h00);
    check(route, 8'h00);
    // Open-drain pin never drives high and is released in reset
    check({6'h0, sda_out, sda_oe}, 8'h00);
    rst = 1'b0;
    pin_n = 1'b0;
    step(2);
    cps_smb_host_i.read_reg(DEV, 8'h03, rd, ok);
    check(rd, 8'h0f);
    cps_smb_host_i.read_reg(DEV, 8'h04, rd, ok);
    check({4'h0, rd[3:0]}, 8'h00);
    test_done();
  end
endmodule
